// file: design/ubrg_top.v
// baud rate generator for four channels of one serial array unit, AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ubrg_defines.vh"
module ubrg_top #(
  parameter UNIT = 0
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer_ch2_tick,
  input  wire        timer_ch3_tick,
  input  wire [3:0]  rxd,
  output reg  [3:0]  baud_tick
);
  // ==========================================================
  // registers
  reg  [7:0]  unit_prescale_select_r;
  reg  [15:0] chan_mode_reg_r [0:3];
  reg  [15:0] chan_data_divider_reg_r [0:3];
  reg  [3:0]  run_r;
  reg  [3:0]  frame_bits_r;
  reg  [3:0]  err_sticky_r;
  reg  [3:0]  ok_sticky_r;
  // ==========================================================
  // input synchronisers: rx pins and timer ticks come from outside
  reg  [3:0]  rxd_s1_r;
  reg  [3:0]  rxd_s2_r;
  reg  [1:0]  tick_s1_r;
  reg  [1:0]  tick_s2_r;
  reg  [1:0]  tick_s3_r;
  always @(posedge mclk) begin
    if (rst) begin
      rxd_s1_r  <= 4'hf;
      rxd_s2_r  <= 4'hf;
      tick_s1_r <= 2'b00;
      tick_s2_r <= 2'b00;
      tick_s3_r <= 2'b00;
    end else begin
      rxd_s1_r  <= rxd;
      rxd_s2_r  <= rxd_s1_r;
      tick_s1_r <= {timer_ch3_tick, timer_ch2_tick};
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
    end
  end
  // ticks arrive as levels of any width; take one pulse per rising edge
  wire [1:0] tick_rise = tick_s2_r & ~tick_s3_r;
  wire       timer_tick = (UNIT == 0) ? tick_rise[0] : tick_rise[1];
  // ==========================================================
  // power of two prescaler: free counter, enable pulses
  reg  [10:0] pre_cnt_r;
  reg  [11:0] pow_tick;
  integer     i;
  always @(posedge mclk) begin
    if (rst)
      pre_cnt_r <= 11'h000;
    else
      pre_cnt_r <= pre_cnt_r + 11'h001;
  end
  // all ones below bit n; n = 11 covers the whole counter
  function [10:0] low_mask;
    input integer n;
    begin
      low_mask = (11'h001 << n) - 11'h001;
    end
  endfunction
  always @* begin
    pow_tick[0] = 1'b1;
    for (i = 1; i < 12; i = i + 1)
      pow_tick[i] = ((pre_cnt_r & low_mask(i)) == low_mask(i));
  end
  // ==========================================================
  // channels
  wire [3:0] tick_w;
  wire [3:0] busy_w;
  wire [3:0] ok_w;
  wire [3:0] ferr_w;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gch
      ubrg_chan u_chan (
        .mclk       (mclk),
        .rst        (rst),
        .run        (run_r[g]),
        .cks        (chan_mode_reg_r[g][`UBRG_MODE_CKS_BIT]),
        .prescale   (unit_prescale_select_r),
        .pow_tick   (pow_tick),
        .timer_tick (timer_tick),
        .divider    (chan_data_divider_reg_r[g][`UBRG_DIV_HI:`UBRG_DIV_LO]),
        .frame_bits (frame_bits_r),
        .rxd        (rxd_s2_r[g]),
        .baud_tick  (tick_w[g]),
        .rx_busy    (busy_w[g]),
        .frame_ok   (ok_w[g]),
        .frame_err  (ferr_w[g])
      );
    end
  endgenerate
  always @(posedge mclk) begin
    if (rst)
      baud_tick <= 4'h0;
    else
      baud_tick <= tick_w;
  end
  // ==========================================================
  // AXI4-Lite write side: address and data taken in either order
  reg  [7:0]  waddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         have_aw_r;
  reg         have_w_r;
  wire        do_write = have_aw_r && have_w_r && !s_axi_bvalid;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `UBRG_OFF_PRESCALE) || (a == `UBRG_OFF_STATUS) || (a == `UBRG_OFF_FRAME) ||
                  (a[7:4] == `UBRG_OFF_MODE_BASE >> 4 && a[1:0] == 2'b00) ||
                  (a[7:4] == `UBRG_OFF_DATA_BASE >> 4 && a[1:0] == 2'b00);
    end
  endfunction

  integer k;
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready          <= 1'b0;
      s_axi_wready           <= 1'b0;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= `UBRG_RESP_OKAY;
      have_aw_r              <= 1'b0;
      have_w_r               <= 1'b0;
      waddr_r                <= 8'h00;
      wdata_r                <= 32'h0000_0000;
      wstrb_r                <= 4'h0;
      unit_prescale_select_r <= 8'h00;
      run_r                  <= 4'h0;
      frame_bits_r           <= `UBRG_FRAME_RST;
      for (k = 0; k < 4; k = k + 1) begin
        chan_mode_reg_r[k]         <= 16'h0000;
        chan_data_divider_reg_r[k] <= 16'h0000;
      end
    end else begin
      s_axi_awready <= !have_aw_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !have_w_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_r <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write) begin
        have_aw_r    <= 1'b0;
        have_w_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(waddr_r) ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
        if (waddr_r == `UBRG_OFF_PRESCALE) begin
          if (wstrb_r[0])
            unit_prescale_select_r <= wdata_r[7:0];
          if (wstrb_r[1])
            run_r <= wdata_r[11:8];
        end
        if (waddr_r == `UBRG_OFF_FRAME && wstrb_r[0])
          frame_bits_r <= wdata_r[3:0];
        if (waddr_r[7:4] == `UBRG_OFF_MODE_BASE >> 4 && waddr_r[1:0] == 2'b00)
          chan_mode_reg_r[waddr_r[3:2]] <= merge16(chan_mode_reg_r[waddr_r[3:2]], wdata_r, wstrb_r);
        if (waddr_r[7:4] == `UBRG_OFF_DATA_BASE >> 4 && waddr_r[1:0] == 2'b00)
          chan_data_divider_reg_r[waddr_r[3:2]] <=
            merge16(chan_data_divider_reg_r[waddr_r[3:2]], wdata_r, wstrb_r);
      end
    end
  end
  // ==========================================================
  // sticky frame flags; hardware set wins over software clear
  wire clr_status = do_write && waddr_r == `UBRG_OFF_STATUS && wstrb_r[0];
  always @(posedge mclk) begin
    if (rst) begin
      err_sticky_r <= 4'h0;
      ok_sticky_r  <= 4'h0;
    end else begin
      err_sticky_r <= ferr_w | (err_sticky_r & ~(clr_status ? wdata_r[3:0] : 4'h0));
      ok_sticky_r  <= ok_w | (ok_sticky_r & ~(clr_status ? wdata_r[7:4] : 4'h0));
    end
  end
  // ==========================================================
  // AXI4-Lite read side
  reg  [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == `UBRG_OFF_PRESCALE)
      rd_val = {20'h00000, run_r, unit_prescale_select_r};
    else if (s_axi_araddr == `UBRG_OFF_STATUS)
      rd_val = {20'h00000, busy_w, ok_sticky_r, err_sticky_r};
    else if (s_axi_araddr == `UBRG_OFF_FRAME)
      rd_val = {28'h0000000, frame_bits_r};
    else if (s_axi_araddr[7:4] == `UBRG_OFF_MODE_BASE >> 4)
      rd_val = {16'h0000, chan_mode_reg_r[s_axi_araddr[3:2]]};
    else if (s_axi_araddr[7:4] == `UBRG_OFF_DATA_BASE >> 4)
      rd_val = {16'h0000, chan_data_divider_reg_r[s_axi_araddr[3:2]]};
  end
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UBRG_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= is_mapped(s_axi_araddr) ? rd_val : 32'h0000_0000;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/ubrg_defines.vh
// constants for the baud rate generator block
// Notes on behaviour
// - bit rate is operation clock divided by (divider + 1), then by two.
// - divider sits in data register bits 15:9, usable 2 to 127.
// - operation clock picked from unit prescale select and mode bit 15.
// - mode bit 0 uses field a, 1 field b; codes 0-11 divide by 2^code.
// - code all ones uses timer tick, ch2 for unit 0, ch3 for unit 1.
// - max rate is Brate*2kN/(2kN-k+2), k = divider+1, N frame bits.
// - min rate is Brate*2k(N-1)/(2kN-k-2).
// - frame length counts start, data, parity and stop bits.
// - receiver times samples from start bit with divider; stop bit checked at last sample.
`ifndef UBRG_DEFINES_VH
`define UBRG_DEFINES_VH
`define UBRG_ADDR_PRESCALE  4'h0
`define UBRG_ADDR_MODE0     4'h4
`define UBRG_ADDR_MODE1     4'h8
`define UBRG_ADDR_MODE2     4'hc
`define UBRG_ADDR_MODE3     4'h0
`define UBRG_AW             8
`define UBRG_OFF_PRESCALE   8'h00
`define UBRG_OFF_MODE_BASE  8'h10
`define UBRG_OFF_DATA_BASE  8'h20
`define UBRG_OFF_STATUS     8'h30
`define UBRG_OFF_FRAME      8'h34
`define UBRG_MODE_CKS_BIT   15
`define UBRG_DIV_HI         15
`define UBRG_DIV_LO         9
`define UBRG_CODE_TIMER     4'hf
`define UBRG_CODE_MAX_DIV   4'hb
`define UBRG_DIV_MIN        7'h02
`define UBRG_RESP_OKAY      2'b00
`define UBRG_RESP_SLVERR    2'b10
`define UBRG_FRAME_RST      4'hb
`endif

// file: design/ubrg_chan.v
// one channel: operation clock select, bit rate divider and receive sample timing
`timescale 1ns/1ps
`default_nettype none
`include "ubrg_defines.vh"
module ubrg_chan (
  input  wire        mclk,
  input  wire        rst,
  input  wire        run,
  input  wire        cks,
  input  wire [7:0]  prescale,
  input  wire [11:0] pow_tick,
  input  wire        timer_tick,
  input  wire [6:0]  divider,
  input  wire [3:0]  frame_bits,
  input  wire        rxd,
  output reg         baud_tick,
  output reg         rx_busy,
  output reg         frame_ok,
  output reg         frame_err
);
  // ==========================================================
  // operation clock select
  reg  [3:0] code;
  reg        op_clk;
  always @* begin
    code = cks ? prescale[7:4] : prescale[3:0];
    if (code == `UBRG_CODE_TIMER)
      op_clk = timer_tick;
    else if (code <= `UBRG_CODE_MAX_DIV)
      op_clk = pow_tick[code];
    else
      op_clk = 1'b0;
  end
  // ==========================================================
  // half bit divider: (divider+1) op clocks per half bit
  reg  [6:0] div_cnt_r;
  reg        half_r;
  wire       div_ok = (divider >= `UBRG_DIV_MIN);
  always @(posedge mclk) begin
    if (rst || !run || !div_ok) begin
      div_cnt_r <= 7'h00;
      half_r    <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (op_clk) begin
        if (div_cnt_r >= divider) begin
          div_cnt_r <= 7'h00;
          half_r    <= ~half_r;
          baud_tick <= half_r;
        end else begin
          div_cnt_r <= div_cnt_r + 7'h01;
        end
      end
    end
  end
  // ==========================================================
  // receive sampling: mid bit points timed from start edge
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  reg  [1:0] st_r;
  reg  [6:0] rcnt_r;
  reg        rhalf_r;
  reg  [3:0] bit_r;
  reg        rxd_d_r;
  always @(posedge mclk) begin
    if (rst || !run || !div_ok) begin
      st_r      <= ST_IDLE;
      rcnt_r    <= 7'h00;
      rhalf_r   <= 1'b0;
      bit_r     <= 4'h0;
      rxd_d_r   <= 1'b1;
      rx_busy   <= 1'b0;
      frame_ok  <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rxd_d_r   <= rxd;
      frame_ok  <= 1'b0;
      frame_err <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (rxd_d_r && !rxd) begin
            st_r    <= ST_RUN;
            rcnt_r  <= 7'h00;
            rhalf_r <= 1'b0;
            bit_r   <= 4'h0;
            rx_busy <= 1'b1;
          end
        end
        ST_RUN: begin
          if (op_clk) begin
            if (rcnt_r >= divider) begin
              rcnt_r  <= 7'h00;
              rhalf_r <= ~rhalf_r;
              // sample at odd half bits, i.e. mid bit
              // first sample half a bit after the start edge centres the tolerance window
              if (!rhalf_r) begin
                if (bit_r == frame_bits - 4'h1) begin
                  st_r      <= ST_IDLE;
                  rx_busy   <= 1'b0;
                  frame_ok  <= rxd;
                  frame_err <= ~rxd;
                end else if (bit_r == 4'h0 && rxd) begin
                  st_r    <= ST_IDLE; // false start
                  rx_busy <= 1'b0;
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            end else begin
              rcnt_r <= rcnt_r + 7'h01;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verification/ubrg_remote_tx.sv
// remote serial transmitter model driving one receive pin
`timescale 1ns/1ps
`default_nettype none
module ubrg_remote_tx (
  input  wire logic mclk,
  output var  logic txd
);
  initial txd = 1'h1;
  // start bit first; line idles high between frames
  task automatic send(input logic [10:0] f, input int per);
    for (int i = 0; i < 11; i++) begin
      txd <= f[i];
      repeat (per) @(posedge mclk);
    end
    txd <= 1'h1;
  endtask
endmodule
`default_nettype wire

// file: verification/ubrg_top_props.sv
// port assertions for the baud rate generator
`timescale 1ns/1ps
`default_nettype none
module ubrg_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  baud_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_AW_CAUSE: assert property (s_axi_awready |-> $past(s_axi_awvalid))
    else $error("awready without awvalid");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // divider of at least 2 keeps ticks six clocks apart
  AST_TICK0_GAP: assert property (baud_tick[0] |=> !baud_tick[0] [*5])
    else $error("channel 0 ticks too close");
  AST_TICK1_GAP: assert property (baud_tick[1] |=> !baud_tick[1] [*5])
    else $error("channel 1 ticks too close");
endmodule
bind ubrg_top ubrg_props ubrg_props_inst (.*);
`default_nettype wire

// file: verification/ubrg_top_test.sv
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
`default_nettype none
module ubrg_top_test;
  // ====
  // signals
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        timer_ch2_tick = 1'h0;
  logic        timer_ch3_tick = 1'h0;
  logic        tmr_run = 1'h1;
  real         er;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0]  baud_tick, rxd;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  int          d;
  logic [31:0] v, p;
  logic [1:0]  r;
  assign rxd = {3'h7, txd};
  ubrg_top #(.UNIT(0)) ubrg_top_inst (.*);
  ubrg_remote_tx ubrg_remote_tx_inst (.mclk(mclk), .txd(txd));
  always #10 mclk = ~mclk;
  // ch3 tick runs faster, so picking the wrong tick shows
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    timer_ch2_tick <= tmr_run & cyc[2];
    timer_ch3_tick <= tmr_run & cyc[0];
    if (cyc == 99000) begin
      miscompares++;
      stop_test();
    end
  end
  // ====
  // tasks
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    dr = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // skipping the first two ticks gives a clean period after a setting change
  task automatic period(input int ch, output logic [31:0] n);
    repeat (2) begin
      @(posedge mclk);
      while (baud_tick[ch] !== 1'h1) @(posedge mclk);
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (baud_tick[ch] !== 1'h1);
  endtask
  // percent error of the achieved rate against the target rate
  function automatic real err_pct(input real got, input real tgt);
    return got / tgt * 100.0 - 100.0;
  endfunction
  function automatic logic [31:0] exp_per(input int c, input int k);
    return 32'(2 * (k + 1)) << c;
  endfunction
  task automatic frame(input logic [31:0] exp, input string m);
    @(posedge mclk);
    ubrg_remote_tx_inst.send(v[10:0], 6);
    repeat (8) @(posedge mclk);
    rd(8'h30, p, r);
    chk(p & 32'hfff, exp, m);
  endtask
  // ====
  // sequence
  initial begin
    v = $urandom(17);
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    for (int n = 0; n < 4; n++) begin
      v = {16'h0, 7'(2 + $urandom % 126), 9'h0};
      wr(8'(8'h20 + 4 * n), v, r);
      rd(8'(8'h20 + 4 * n), p, r);
      chk(p, v, "divider readback");
    end
    rd(8'h40, p, r);
    chk({p[31:2], r}, 32'h2, "unmapped read");
    wr(8'h44, 32'h1, r);
    chk(32'(r), 32'h2, "unmapped write");
    wr(8'h10, 32'h0, r);
    wr(8'h20, 32'h400, r);
    for (int c = 0; c < 12; c++) begin
      wr(8'h00, 32'h0, r);
      wr(8'h00, 32'h100 | c, r);
      period(0, p);
      chk(p, exp_per(c, 2), "prescaled period");
    end
    wr(8'h00, 32'h100, r);
    wr(8'h20, 32'h200, r);
    d = 0;
    repeat (64) begin
      @(posedge mclk);
      d += baud_tick[0];
    end
    chk(d, 0, "divider one ticks");
    d = 2 + $urandom % 8;
    wr(8'h00, 32'h0, r);
    wr(8'h14, 32'h8000, r);
    wr(8'h1c, 32'h8000, r);
    for (int n = 0; n < 4; n++) wr(8'(8'h20 + 4 * n), d << 9, r);
    wr(8'h00, 32'hf20, r);
    period(1, p);
    chk(p, exp_per(2, d), "field b period");
    er = err_pct(1.0e9 / (real'(p) * 20.0), 50.0e6 / (8.0 * real'(d + 1)));
    chk(32'($rtoi(er * 1000.0)), 32'h0, "rate error");
    period(3, p);
    chk(p, exp_per(2, d), "field b period ch3");
    period(0, p);
    chk(p, exp_per(0, d), "field a period");
    period(2, p);
    chk(p, exp_per(0, d), "field a period ch2");
    wr(8'h00, 32'h10f, r);
    wr(8'h20, 32'h400, r);
    period(0, p);
    chk(p, 32'h30, "timer tick period");
    tmr_run <= 1'h0;
    wr(8'h00, 32'h100, r);
    wr(8'h30, 32'hff, r);
    v = {21'h0, 1'h1, 1'h0, 8'($urandom), 1'h0};
    frame(32'h010, "good frame");
    v[10] = 1'h0;
    frame(32'h011, "late stop bit");
    wr(8'h30, 32'h11, r);
    rd(8'h30, p, r);
    chk(p & 32'hfff, 32'h0, "status clear");
    stop_test();
  end
endmodule
`default_nettype wire
